//--- hdl/pwm_synced_adc_trigger_params.svh
// Purpose: constants for the pwm synchronised converter trigger block
// Assumes: 50 MHz reference clock, timer counting at carrier rate times carrier counts
// Notes:
`ifndef PWM_SYNCED_ADC_TRIGGER_PARAMS_SVH
`define PWM_SYNCED_ADC_TRIGGER_PARAMS_SVH

`define CLK_HZ 50000000
`define CARRIER_HZ 5000
`define CARRIER_COUNTS 1000
`define HALF_COUNTS 500
`define DEAD_TIME_NS 4000
`define TIMER_HZ (`CARRIER_HZ * `CARRIER_COUNTS)
`define TICK_DIV (`CLK_HZ / `TIMER_HZ)
`define DEAD_COUNTS ((`DEAD_TIME_NS * (`TIMER_HZ / 1000)) / 1000000)
`define CNT_W 16
`define DATA_W 12
`define PHASES 3
`define CH_AN_ZERO 1'b0
`define CH_AN_ONE 1'b1
`define RESULT_RST 12'h000

`endif

//--- hdl/pwm_synced_adc_trigger_pkg.sv
// Purpose: types shared by the trigger block and its converter sequencer
// Assumes: 12-bit conversion results
// Notes: constants live in the params header
package pwm_synced_adc_trigger_pkg;

   typedef enum logic {
      DIR_UP,
      DIR_DOWN
   } count_dir_e;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_WAIT
   } seq_state_e;

   typedef enum logic [1:0] {
      SLOT_FIRST,
      SLOT_DUP,
      SLOT_GRP_B
   } slot_e;

   typedef struct packed {
      logic [11:0] first;
      logic [11:0] dup;
      logic [11:0] grp_b;
   } conv_results_s;

   typedef struct packed {
      logic start;
      logic channel;
   } conv_req_s;

endpackage

//--- hdl/adc_group_sequencer.sv
// Purpose: queues group conversion triggers, starts the converter and files results
// Assumes: converter answers each start with one conv_done_i pulse on the same clock
// Notes: group A first slot has priority, then duplicate slot, then group B
`timescale 1ns/100ps
`include "pwm_synced_adc_trigger_params.svh"
module adc_group_sequencer
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // triggers
   input wire logic trig_first_i,
   input wire logic trig_dup_i,
   input wire logic trig_grp_b_i,
   // converter
   input wire logic conv_done_i,
   input wire logic [11:0] conv_data_i,
   output pwm_synced_adc_trigger_pkg::conv_req_s conv_req_o,
   // results
   output pwm_synced_adc_trigger_pkg::conv_results_s results_o
);

   pwm_synced_adc_trigger_pkg::seq_state_e state_q;
   pwm_synced_adc_trigger_pkg::slot_e slot_q;
   logic [2:0] pend_q;
   logic [2:0] grant;
   logic [2:0] trig;

   assign trig = {trig_grp_b_i, trig_dup_i, trig_first_i};
   // fixed priority pick among pending slots
   assign grant = (state_q == pwm_synced_adc_trigger_pkg::SEQ_IDLE) ? (pend_q & ~(pend_q - 3'h1)) : 3'h0;

   // each slot keeps its own pending flag; a new trigger wins over the clear
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pend_q <= 3'h0;
      else
         pend_q <= (pend_q & ~grant) | trig;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_q <= pwm_synced_adc_trigger_pkg::SEQ_IDLE;
         slot_q <= pwm_synced_adc_trigger_pkg::SLOT_FIRST;
         conv_req_o <= '0;
      end
      else
      begin
         conv_req_o.start <= 1'b0;
         unique case (state_q)
            pwm_synced_adc_trigger_pkg::SEQ_IDLE:
               if (grant != 3'h0)
               begin
                  state_q <= pwm_synced_adc_trigger_pkg::SEQ_WAIT;
                  conv_req_o.start <= 1'b1;
                  if (grant[2])
                  begin
                     slot_q <= pwm_synced_adc_trigger_pkg::SLOT_GRP_B;
                     conv_req_o.channel <= `CH_AN_ONE;
                  end
                  else
                  begin
                     slot_q <= grant[1] ? pwm_synced_adc_trigger_pkg::SLOT_DUP : pwm_synced_adc_trigger_pkg::SLOT_FIRST;
                     conv_req_o.channel <= `CH_AN_ZERO;
                  end
               end
            pwm_synced_adc_trigger_pkg::SEQ_WAIT:
               if (conv_done_i)
                  state_q <= pwm_synced_adc_trigger_pkg::SEQ_IDLE;
            default:
               state_q <= pwm_synced_adc_trigger_pkg::SEQ_IDLE;
         endcase
      end
   end

   // separate result registers so the duplicate never overwrites the first
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         results_o <= {`RESULT_RST, `RESULT_RST, `RESULT_RST};
      else if (state_q == pwm_synced_adc_trigger_pkg::SEQ_WAIT && conv_done_i)
      begin
         unique case (slot_q)
            pwm_synced_adc_trigger_pkg::SLOT_FIRST: results_o.first <= conv_data_i;
            pwm_synced_adc_trigger_pkg::SLOT_DUP: results_o.dup <= conv_data_i;
            pwm_synced_adc_trigger_pkg::SLOT_GRP_B: results_o.grp_b <= conv_data_i;
            default: results_o.grp_b <= conv_data_i;
         endcase
      end
   end

endmodule

//--- hdl/pwm_synced_adc_trigger.sv
// Purpose: triangular pwm timer with dead time that triggers group converter scans
// Assumes: compare and period inputs are quasi-static and come from logic on ref_clk_i
// Notes: timer counts once every TICK_DIV reference clocks
`timescale 1ns/100ps
`include "pwm_synced_adc_trigger_params.svh"
module pwm_synced_adc_trigger
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // timer setup
   input wire logic timer_run_i,
   input wire logic [15:0] half_period_i,
   input wire logic [15:0] duty_compare_i,
   input wire logic [15:0] conv_trigger_compare_a_i,
   input wire logic [15:0] conv_trigger_compare_b_i,
   input wire logic [15:0] ch3_general_compare_a_i,
   // converter
   input wire logic conv_done_i,
   input wire logic [11:0] conv_data_i,
   output pwm_synced_adc_trigger_pkg::conv_req_s conv_req_o,
   output pwm_synced_adc_trigger_pkg::conv_results_s results_o,
   // power stage
   output logic [2:0] pwm_pos_o,
   output logic [2:0] pwm_neg_o,
   output logic carrier_toggle_o,
   // status
   output logic ch3_compare_interrupt_o,
   output logic [15:0] timer_counter_value_o
);

   localparam logic [3:0] TICK_LAST = 4'(`TICK_DIV - 1);
   localparam logic [15:0] DEAD_CNT = 16'(`DEAD_COUNTS);

   logic rst_meta_q;
   logic rst_sync_q;
   logic rstn;
   logic [3:0] div_q;
   logic tick;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   pwm_synced_adc_trigger_pkg::count_dir_e dir_q;
   pwm_synced_adc_trigger_pkg::count_dir_e dir_d;
   logic [15:0] ch3_cnt_d;
   logic underflow_d;
   logic peak_d;
   logic trig_first_q;
   logic trig_dup_q;
   logic trig_grp_b_q;

   // true when the timer steps onto the compare value
   function automatic logic count_meets(input logic step, input logic [15:0] cnt, input logic [15:0] cmp);
      count_meets = step && (cnt == cmp);
   endfunction

   // reset released through two flops
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign rstn = rst_sync_q;

   // timer count prescaler
   always_ff @(posedge ref_clk_i or negedge rstn)
   begin
      if (!rstn)
         div_q <= 4'h0;
      else if (!timer_run_i || div_q == TICK_LAST)
         div_q <= 4'h0;
      else
         div_q <= div_q + 4'h1;
   end

   assign tick = timer_run_i && (div_q == TICK_LAST);

   // triangular count up to the half period and back to zero
   always_comb
   begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      underflow_d = 1'b0;
      peak_d = 1'b0;
      if (tick)
      begin
         if (dir_q == pwm_synced_adc_trigger_pkg::DIR_UP)
         begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_d >= half_period_i)
            begin
               dir_d = pwm_synced_adc_trigger_pkg::DIR_DOWN;
               peak_d = 1'b1;
            end
         end
         else
         begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_d == 16'h0000)
            begin
               dir_d = pwm_synced_adc_trigger_pkg::DIR_UP;
               underflow_d = 1'b1;
            end
         end
      end
   end

   // channel three runs ahead of channel four by the dead time
   assign ch3_cnt_d = cnt_d + DEAD_CNT;

   always_ff @(posedge ref_clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_q <= 16'h0000;
         dir_q <= pwm_synced_adc_trigger_pkg::DIR_UP;
      end
      else
      begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn)
   begin
      if (!rstn)
         timer_counter_value_o <= 16'h0000;
      else
         timer_counter_value_o <= cnt_d;
   end

   // period toggle output flips at every peak
   always_ff @(posedge ref_clk_i or negedge rstn)
   begin
      if (!rstn)
         carrier_toggle_o <= 1'b0;
      else if (peak_d)
         carrier_toggle_o <= ~carrier_toggle_o;
   end

   // converter triggers, one pulse each
   always_ff @(posedge ref_clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         trig_first_q <= 1'b0;
         trig_dup_q <= 1'b0;
         trig_grp_b_q <= 1'b0;
      end
      else
      begin
         trig_first_q <= count_meets(tick, cnt_d, conv_trigger_compare_a_i);
         trig_dup_q <= count_meets(tick, cnt_d, conv_trigger_compare_b_i);
         trig_grp_b_q <= underflow_d;
      end
   end

   // software collects results on this pulse
   always_ff @(posedge ref_clk_i or negedge rstn)
   begin
      if (!rstn)
         ch3_compare_interrupt_o <= 1'b0;
      else
         ch3_compare_interrupt_o <= count_meets(tick, ch3_cnt_d, ch3_general_compare_a_i);
   end

   // identical complementary pairs with dead time
   genvar ph;
   generate
      for (ph = 0; ph < `PHASES; ph = ph + 1)
      begin : g_phase
         logic raw_q;
         logic raw_d;
         logic [15:0] dead_q;

         assign raw_d = (cnt_q >= duty_compare_i);

         always_ff @(posedge ref_clk_i or negedge rstn)
         begin
            if (!rstn)
               raw_q <= 1'b0;
            else
               raw_q <= raw_d;
         end

         // blanking counter restarts on every edge of the raw wave
         always_ff @(posedge ref_clk_i or negedge rstn)
         begin
            if (!rstn)
               dead_q <= DEAD_CNT;
            else if (raw_d != raw_q)
               dead_q <= DEAD_CNT;
            else if (tick && dead_q != 16'h0000)
               dead_q <= dead_q - 16'h0001;
         end

         // both sides low while blanking or at an edge, so a pair never overlaps
         always_ff @(posedge ref_clk_i or negedge rstn)
         begin
            if (!rstn)
            begin
               pwm_pos_o[ph] <= 1'b0;
               pwm_neg_o[ph] <= 1'b0;
            end
            else
            begin
               pwm_pos_o[ph] <= raw_q && (dead_q == 16'h0000) && (raw_d == raw_q);
               pwm_neg_o[ph] <= !raw_q && (dead_q == 16'h0000) && (raw_d == raw_q);
            end
         end
      end
   endgenerate

   adc_group_sequencer u_seq
   (
      .clk_i(ref_clk_i),
      .rstn_i(rstn),
      .trig_first_i(trig_first_q),
      .trig_dup_i(trig_dup_q),
      .trig_grp_b_i(trig_grp_b_q),
      .conv_done_i(conv_done_i),
      .conv_data_i(conv_data_i),
      .conv_req_o(conv_req_o),
      .results_o(results_o)
   );

endmodule

//--- test/pwm_trig_sva.sv
// Purpose: port checks for the pwm synchronised converter trigger
// Assumes: tick every 10 clocks, dead band of 20 ticks
// Notes: bound to the top module below
`timescale 1ns/100ps
module pwm_trig_sva
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // setup and converter
   input wire logic [15:0] half_period_i,
   input wire logic [15:0] conv_trigger_compare_a_i,
   input wire logic [15:0] ch3_general_compare_a_i,
   input wire logic conv_done_i,
   // outputs
   input wire pwm_synced_adc_trigger_pkg::conv_req_s conv_req_o,
   input wire pwm_synced_adc_trigger_pkg::conv_results_s results_o,
   input wire logic [2:0] pwm_pos_o,
   input wire logic [2:0] pwm_neg_o,
   input wire logic carrier_toggle_o,
   input wire logic ch3_compare_interrupt_o,
   input wire logic [15:0] timer_counter_value_o
);
   wire [15:0] cnt = timer_counter_value_o;
   logic [8:0] lo_q;
   // cycles with both sides of a pair low
   always_ff @(posedge ref_clk_i or negedge rstn_i)
      if (!rstn_i)
         lo_q <= 9'h000;
      else if (pwm_pos_o[0] | pwm_neg_o[0])
         lo_q <= 9'h000;
      else if (lo_q != 9'h1ff)
         lo_q <= lo_q + 9'h001;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   chk_pair_apart: assert property (!(pwm_pos_o & pwm_neg_o))
      else $error("pair overlap");
   chk_dead_band: assert property ($rose(pwm_pos_o[0]) || $rose(pwm_neg_o[0]) |-> lo_q >= 9'd190)
      else $error("dead band short");
   chk_phase_same: assert property (pwm_pos_o inside {3'h0, 3'h7} && pwm_neg_o inside {3'h0, 3'h7})
      else $error("phases differ");
   chk_a_start: assert property ($changed(cnt) && cnt == conv_trigger_compare_a_i
      |-> ##[1:200] conv_req_o.start && !conv_req_o.channel)
      else $error("group a start missing");
   chk_under_start: assert property ($changed(cnt) && cnt == 16'h0000
      |-> ##[1:200] conv_req_o.start && conv_req_o.channel)
      else $error("group b start missing");
   chk_start_pulse: assert property (conv_req_o.start |=> !conv_req_o.start)
      else $error("start too long");
   chk_irq_cause: assert property (ch3_compare_interrupt_o |-> $changed(cnt) && cnt + 16'h0014 == ch3_general_compare_a_i)
      else $error("stray interrupt");
   chk_irq_fire: assert property ($changed(cnt) && cnt + 16'h0014 == ch3_general_compare_a_i |-> ch3_compare_interrupt_o)
      else $error("interrupt missing");
   chk_cnt_step: assert property ($changed(cnt) |-> cnt == $past(cnt) + 16'h0001 || cnt == $past(cnt) - 16'h0001)
      else $error("count jump");
   chk_cnt_peak: assert property (cnt <= half_period_i)
      else $error("count above peak");
   chk_toggle_peak: assert property ($changed(carrier_toggle_o) |-> cnt == half_period_i || $past(cnt) == half_period_i)
      else $error("toggle off peak");
   chk_result_done: assert property ($changed(results_o) |-> $past(conv_done_i))
      else $error("result without done");
   cover property (ch3_compare_interrupt_o);
   cover property (conv_req_o.start && conv_req_o.channel);
   cover property ($rose(pwm_pos_o[0]));
endmodule
bind pwm_synced_adc_trigger pwm_trig_sva u_sva (.ref_clk_i, .rstn_i, .half_period_i, .conv_trigger_compare_a_i,
   .ch3_general_compare_a_i, .conv_done_i, .conv_req_o, .results_o, .pwm_pos_o, .pwm_neg_o, .carrier_toggle_o,
   .ch3_compare_interrupt_o, .timer_counter_value_o);

//--- test/conv_model.sv
// Purpose: behavioural converter answering each start after lat_i clocks
// Assumes: one start in flight at a time
// Notes: data line changes every idle cycle
`timescale 1ns/100ps
module conv_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // request and analog levels
   input wire pwm_synced_adc_trigger_pkg::conv_req_s req_i,
   input wire logic [7:0] lat_i,
   input wire logic [11:0] an_zero_i,
   input wire logic [11:0] an_one_i,
   // answer
   output logic done_o,
   output logic [11:0] data_o
);
   logic [7:0] wait_q;
   logic [11:0] smp_q;
   // done is written once per edge so it stays a clean one-cycle pulse
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wait_q <= 8'h00;
         done_o <= 1'b0;
         data_o <= 12'ha5a;
      end
      else if (req_i.start)
      begin
         smp_q <= req_i.channel ? an_one_i : an_zero_i;
         wait_q <= lat_i;
         done_o <= 1'b0;
      end
      else if (wait_q == 8'h01)
      begin
         done_o <= 1'b1;
         data_o <= smp_q;
         wait_q <= 8'h00;
      end
      else
      begin
         done_o <= 1'b0;
         if (wait_q > 8'h01)
            wait_q <= wait_q - 8'h01;
         else
            data_o <= ~data_o;
      end
   end
endmodule

//--- test/pwm_synced_adc_trigger_test.sv
// Purpose: self-checking bench for the pwm synchronised converter trigger
// Assumes: 50 MHz clock, half carrier of 500 counts
// Notes: one carrier is 10000 clocks
`timescale 1ns/100ps
module pwm_synced_adc_trigger_test;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic run = 1'b0;
   logic [15:0] half = 16'h01f4;
   logic [15:0] duty = 16'h00fa;
   logic [15:0] cmp3 = 16'h0208;
   logic [15:0] cmp_a = 16'h0064;
   logic [15:0] cmp_b = 16'h0190;
   logic [7:0] lat = 8'h02;
   logic [11:0] an0 = 12'h111;
   logic done;
   logic [11:0] data;
   pwm_synced_adc_trigger_pkg::conv_req_s req;
   pwm_synced_adc_trigger_pkg::conv_results_s res;
   logic [2:0] pos;
   logic [2:0] neg;
   logic tog;
   logic irq;
   logic [15:0] cnt;
   int failures = 0;
   int n_checks = 0;
   initial
      forever #10 ref_clk_i = ~ref_clk_i;
   pwm_synced_adc_trigger DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .timer_run_i(run),
      .half_period_i(half), .duty_compare_i(duty), .conv_trigger_compare_a_i(cmp_a),
      .conv_trigger_compare_b_i(cmp_b), .ch3_general_compare_a_i(cmp3), .conv_done_i(done),
      .conv_data_i(data), .conv_req_o(req), .results_o(res), .pwm_pos_o(pos), .pwm_neg_o(neg),
      .carrier_toggle_o(tog), .ch3_compare_interrupt_o(irq), .timer_counter_value_o(cnt));
   conv_model partner (.clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req), .lat_i(lat), .an_zero_i(an0),
      .an_one_i(12'h5a5), .done_o(done), .data_o(data));
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #2;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_cnt(input logic [15:0] v);
      for (int i = 0; i < 20000 && cnt !== v; i++)
         tick(1);
      if (cnt !== v)
      begin
         failures++;
         $display("MISMATCH count wait expected %h seen %h", v, cnt);
         complete_run();
      end
   endtask
   task automatic test_reset;
      check("results", 16'h0000, {4'h0, res.first | res.dup | res.grp_b});
      check("outputs", 16'h0000, {6'h00, pos, neg, tog, irq, req});
      check("count", 16'h0000, cnt);
      $display("test_reset done");
   endtask
   task automatic test_period;
      run = 1'b1;
      wait_cnt(16'h00fa);
      an0 = 12'h222;
      wait_cnt(16'h01f4);
      check("interrupt", 16'h0001, {15'h0000, irq});
      check("first up", 16'h0111, {4'h0, res.first});
      check("dup up", 16'h0222, {4'h0, res.dup});
      check("pwm at peak", 16'h0038, {10'h000, pos, neg});
      an0 = 12'h333;
      wait_cnt(16'h00fa);
      check("dup down", 16'h0333, {4'h0, res.dup});
      an0 = 12'h444;
      wait_cnt(16'h0000);
      check("pwm at trough", 16'h0007, {10'h000, pos, neg});
      check("first down", 16'h0444, {4'h0, res.first});
      tick(100);
      check("group b", 16'h05a5, {4'h0, res.grp_b});
      check("toggle", 16'h0001, {15'h0000, tog});
      $display("test_period done");
   endtask
   task automatic test_burst;
      lat = 8'h1e;
      an0 = 12'h6b6;
      cmp_a = 16'h00c8;
      cmp_b = 16'h00c9;
      wait_cnt(16'h00d2);
      check("first burst", 16'h06b6, {4'h0, res.first});
      check("dup burst", 16'h06b6, {4'h0, res.dup});
      run = 1'b0;
      tick(50);
      check("count hold", 16'h00d2, cnt);
      run = 1'b1;
      tick(15);
      check("count resume", 16'h00d3, cnt);
      $display("test_burst done");
   endtask
   initial
   begin
      tick(8);
      rstn_i = 1'b1;
      tick(3);
      test_reset();
      test_period();
      test_burst();
      complete_run();
   end
endmodule
